//--- color_sense_regs.vh
// Register map, field positions, codes and timing constants of the color sensor controller.
// Assumes inclusion by the controller design, checker and bench files; holds definitions and no logic.
`ifndef COLOR_SENSE_REGS_VH
`define COLOR_SENSE_REGS_VH

// ----------------------------------------------------------------------------
// Register port address
// ----------------------------------------------------------------------------
`define DEV_I2C_ADDR        7'h49

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ADDR_IRQ_PIN_SETUP  8'h22
`define ADDR_RES_N_HI       8'h40
`define ADDR_RES_N_LO       8'h41
`define ADDR_RES_X_HI       8'h42
`define ADDR_RES_X_LO       8'h43
`define ADDR_RES_Y_HI       8'h44
`define ADDR_RES_Y_LO       8'h45
`define ADDR_RES_Z_HI       8'h46
`define ADDR_RES_Z_LO       8'h47
`define ADDR_CONV_CONTROL   8'hAF
`define ADDR_INTEG_TIME     8'hB5
`define ADDR_WAIT_TIME      8'hB6
`define ADDR_BANK_SELECT    8'hB7
`define ADDR_GAIN_DRIVE     8'hB9
`define ADDR_AUTO_ZERO      8'hBA
`define ADDR_TEMP_CONTROL   8'hD0
`define ADDR_TEMP_LOW       8'hD1
`define ADDR_TEMP_HIGH      8'hD2
`define ADDR_FLAG_CLEAR     8'hF8
`define ADDR_FLAG_ENABLE    8'hF9

// ----------------------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------------------
`define BIT_BANK            7
`define BIT_AZ_DONE         7
`define BIT_FLAG            2
`define BIT_CONV_ENABLE     0
`define BIT_CONV_RUN        1
`define BIT_CONV_LATCH      7
`define IRQ_PIN_ON          8'hCA
`define TEMP_CMD_START      8'h24
`define TEMP_STAT_DONE      8'h84
`define RESET_BYTE          8'h00
`define ZERO_BYTE           8'h00

// ----------------------------------------------------------------------------
// Photodiode identifiers carried with each converter sample
// ----------------------------------------------------------------------------
`define PD_X                3'h0
`define PD_Y                3'h1
`define PD_Z                3'h2
`define PD_NIR              3'h3
`define PD_B440             3'h4
`define PD_B490             3'h5

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_MHZ             125
`define T_MIN_CONV_US       2800
`define T_STEP_US           1000

`endif

//--- color_sense_ctrl.v
// Conversion control, result buffering and register file of a six-photodiode color sensor.
// Assumes a byte register port already decoded from the serial bus, and an analog front end
// that streams 16-bit results tagged with a photodiode id and pulses az_done and temp_done.
//
// Function
// - Converter results pass stage, shadow and visible buffers, never seen partial.
// - Bank 0 maps B490,X,Y,B440; bank 1 maps NIR,X,Y,Z to N,X,Y,Z.
// - Each bank conversion lasts one integration time; both banks need two.
// - A single bank conversion never lasts less than 2.8 ms.
// - Gain register bits 1:0 choose 1x, 3.7x, 16x or 64x.
// - A wait period in integration units separates integration cycles.
// - Auto-zero runs once before the first conversion after reset.
// - Writing auto-zero register starts calibration; bit 7 set when finished.
// - With pin setup 0xCA and 0xF9 bit 2 set the interrupt goes high on completion.
// - Writing 0x04 to 0xF8 clears interrupt and polled bit.
// - Pin setup 0x00 leaves pin unused; 0xF8 reads 0x00 or 0x04.
// - Writing 0x83 latches results coherently; host reads one bank per cycle.
// - Conversion repeats continuously; completion shown only by flag and interrupt.
// - Temperature control 0x24 starts measurement, reads 0x84 when done.
// - Temperature result is ten bits: 0xD2 bits 1:0, 0xD1 bits 7:0.
// - Register port answers only at device address 0x49.
// - Results store the high byte at the lower address; temperature stores it at the higher.
// - Pin setup register resets to 0x00, interrupt disabled.
`timescale 1ns/100ps
`include "color_sense_regs.vh"

// ----------------------------------------------------------------------------
// Sample FIFO
// ----------------------------------------------------------------------------
module sample_fifo #(
  parameter WIDTH = 19,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and control
  input  wire             core_clk,
  input  wire             srst,
  input  wire             ce,
  // Filling side
  input  wire             in_valid,
  output reg              in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Draining side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  localparam [AW:0] FULL_CNT = DEPTH;

  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wr_ptr;
  reg  [AW-1:0]    rd_ptr;
  reg  [AW:0]      count;
  wire             push = in_valid & in_ready;
  wire             pop  = out_valid & out_ready;
  wire [AW:0]      next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];

  // Ready is registered from the next count so the front end sees full one cycle early enough.
  always @(posedge core_clk) begin
    if (srst) begin
      wr_ptr   <= {AW{1'b0}};
      rd_ptr   <= {AW{1'b0}};
      count    <= {(AW+1){1'b0}};
      in_ready <= 1'b1;
    end else if (ce) begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr      <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count    <= next_count;
      in_ready <= (next_count != FULL_CNT);
    end
  end
endmodule

// ----------------------------------------------------------------------------
// Controller
// ----------------------------------------------------------------------------
module color_sense_ctrl #(
  parameter STEP_CYCLES     = `T_STEP_US * `CLK_MHZ,
  parameter MIN_CONV_CYCLES = `T_MIN_CONV_US * `CLK_MHZ,
  parameter FIFO_DEPTH      = 8,
  parameter FIFO_AW         = 3
) (
  // Clock, reset, enable
  input  wire        core_clk,
  input  wire        srst,
  input  wire        ce,
  // Register port
  input  wire [6:0]  dev_addr,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  output reg         reg_ack,
  // Converter sample stream
  input  wire        adc_valid,
  input  wire [2:0]  adc_chan,
  input  wire [15:0] adc_data,
  output wire        adc_ready,
  // Front end control
  output reg         integ_active,
  output reg  [1:0]  gain_sel,
  output reg         bank_sel,
  output reg         az_start,
  input  wire        az_done,
  output reg         temp_start,
  input  wire        temp_done,
  input  wire [9:0]  temp_value,
  // Completion interrupt
  output reg         conv_irq
);
  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_AZ    = 3'd1;
  localparam [2:0] ST_INTEG = 3'd2;
  localparam [2:0] ST_XFER  = 3'd3;
  localparam [2:0] ST_WAIT  = 3'd4;
  localparam [31:0] STEP_C  = STEP_CYCLES;
  localparam [31:0] MIN_C   = MIN_CONV_CYCLES;

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg  [7:0]  irq_pin_setup;
  reg  [7:0]  conv_ctl;
  reg  [7:0]  integ_time;
  reg  [7:0]  wait_time;
  reg         bank_reg;
  reg  [7:0]  gain_and_drive_reg;
  reg  [3:0]  az_enables;
  reg         az_done_bit;
  reg         az_pending;
  reg  [7:0]  temp_measure_control;
  reg  [9:0]  temperature_raw_value;
  reg         flag_en;
  reg         done_flag;
  reg  [2:0]  state;
  reg  [31:0] timer;
  reg  [15:0] stage_n, stage_x, stage_y, stage_z;
  reg  [15:0] shadow_n, shadow_x, shadow_y, shadow_z;
  reg  [15:0] result_n_pair, result_x_pair, result_y_pair, result_z_pair;

  wire        sel      = (dev_addr == `DEV_I2C_ADDR);
  wire        wr       = ce & reg_wr & sel;
  wire        rd       = ce & reg_rd & sel;
  wire        running  = conv_ctl[`BIT_CONV_RUN] & conv_ctl[`BIT_CONV_ENABLE];
  wire [31:0] integ_len_raw = ({24'h0, integ_time} + 32'h1) * STEP_C;
  wire [31:0] conv_len = (integ_len_raw < MIN_C) ? MIN_C : integ_len_raw;
  wire [31:0] wait_len = {24'h0, wait_time} * STEP_C;
  wire        drain    = (state == ST_INTEG) || (state == ST_XFER);
  wire        s_valid;
  wire [18:0] s_data;
  wire [2:0]  s_chan   = s_data[18:16];
  wire        pop      = ce & s_valid & drain;
  wire        finish   = (state == ST_XFER) & ~s_valid;

  sample_fifo #(
    .WIDTH (19),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .core_clk  (core_clk),
    .srst      (srst),
    .ce        (ce),
    .in_valid  (adc_valid),
    .in_ready  (adc_ready),
    .in_data   ({adc_chan, adc_data}),
    .out_valid (s_valid),
    .out_ready (drain),
    .out_data  (s_data)
  );

  // --------------------------------------------------------------------------
  // Register writes and status flags
  // --------------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (srst) begin
      irq_pin_setup        <= `RESET_BYTE;
      conv_ctl             <= `RESET_BYTE;
      integ_time           <= `RESET_BYTE;
      wait_time            <= `RESET_BYTE;
      bank_reg             <= 1'b0;
      gain_and_drive_reg   <= `RESET_BYTE;
      az_enables           <= 4'h0;
      az_done_bit          <= 1'b0;
      temp_measure_control <= `RESET_BYTE;
      temperature_raw_value <= 10'h000;
      temp_start           <= 1'b0;
      flag_en              <= 1'b0;
      done_flag            <= 1'b0;
      result_n_pair        <= 16'h0000;
      result_x_pair        <= 16'h0000;
      result_y_pair        <= 16'h0000;
      result_z_pair        <= 16'h0000;
    end else if (ce) begin
      temp_start <= 1'b0;
      if (wr) begin
        case (reg_addr)
          `ADDR_IRQ_PIN_SETUP: irq_pin_setup      <= reg_wdata;
          `ADDR_INTEG_TIME:    integ_time         <= reg_wdata;
          `ADDR_WAIT_TIME:     wait_time          <= reg_wdata;
          `ADDR_BANK_SELECT:   bank_reg           <= reg_wdata[`BIT_BANK];
          `ADDR_GAIN_DRIVE:    gain_and_drive_reg <= reg_wdata;
          `ADDR_FLAG_ENABLE:   flag_en            <= reg_wdata[`BIT_FLAG];
          `ADDR_AUTO_ZERO:     az_enables         <= reg_wdata[3:0];
          `ADDR_CONV_CONTROL: begin
            conv_ctl <= reg_wdata;
            if (reg_wdata[`BIT_CONV_LATCH]) begin
              result_n_pair <= shadow_n;
              result_x_pair <= shadow_x;
              result_y_pair <= shadow_y;
              result_z_pair <= shadow_z;
            end
          end
          `ADDR_TEMP_CONTROL: begin
            temp_measure_control <= reg_wdata;
            temp_start           <= (reg_wdata == `TEMP_CMD_START);
          end
          default: begin
          end
        endcase
      end
      if (temp_done && temp_measure_control == `TEMP_CMD_START) begin
        temp_measure_control  <= `TEMP_STAT_DONE;
        temperature_raw_value <= temp_value;
      end
      // A write marks the calibration as outstanding; a finish in the same cycle belongs to the
      // earlier run, so the fresh request keeps the bit low.
      if (wr && reg_addr == `ADDR_AUTO_ZERO) begin
        az_done_bit <= 1'b0;
      end else if (az_done && state == ST_AZ) begin
        az_done_bit <= 1'b1;
      end
      // Completion set wins over a clear arriving in the same cycle.
      if (finish && flag_en) begin
        done_flag <= 1'b1;
      end else if (wr && reg_addr == `ADDR_FLAG_CLEAR && reg_wdata[`BIT_FLAG]) begin
        done_flag <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Conversion sequencer
  // --------------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (srst) begin
      state        <= ST_IDLE;
      timer        <= 32'h0;
      az_pending   <= 1'b1;
      az_start     <= 1'b0;
      integ_active <= 1'b0;
      bank_sel     <= 1'b0;
      gain_sel     <= 2'b00;
      conv_irq     <= 1'b0;
    end else if (ce) begin
      az_start <= 1'b0;
      gain_sel <= gain_and_drive_reg[1:0];
      conv_irq <= done_flag & (irq_pin_setup == `IRQ_PIN_ON);
      if (wr && reg_addr == `ADDR_AUTO_ZERO) begin
        az_pending <= 1'b1;
      end
      case (state)
        ST_IDLE: begin
          if (az_pending) begin
            state    <= ST_AZ;
            az_start <= 1'b1;
          end else if (running) begin
            state        <= ST_INTEG;
            timer        <= conv_len;
            bank_sel     <= bank_reg;
            integ_active <= 1'b1;
          end
        end
        ST_AZ: begin
          if (az_done) begin
            state <= ST_IDLE;
            if (!(wr && reg_addr == `ADDR_AUTO_ZERO)) begin
              az_pending <= 1'b0;
            end
          end
        end
        ST_INTEG: begin
          if (timer <= 32'h1) begin
            state        <= ST_XFER;
            integ_active <= 1'b0;
          end else begin
            timer <= timer - 32'h1;
          end
        end
        ST_XFER: begin
          if (!s_valid) begin
            state <= ST_WAIT;
            timer <= wait_len;
          end
        end
        ST_WAIT: begin
          if (timer <= 32'h1) begin
            // Any stop or fresh calibration request is honoured between cycles.
            if (running && !az_pending) begin
              state        <= ST_INTEG;
              timer        <= conv_len;
              bank_sel     <= bank_reg;
              integ_active <= 1'b1;
            end else begin
              state <= ST_IDLE;
            end
          end else begin
            timer <= timer - 32'h1;
          end
        end
        default: begin
          state        <= ST_IDLE;
          integ_active <= 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Result staging
  // --------------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (srst) begin
      stage_n  <= 16'h0000;
      stage_x  <= 16'h0000;
      stage_y  <= 16'h0000;
      stage_z  <= 16'h0000;
      shadow_n <= 16'h0000;
      shadow_x <= 16'h0000;
      shadow_y <= 16'h0000;
      shadow_z <= 16'h0000;
    end else if (ce) begin
      if (pop) begin
        case (s_chan)
          `PD_X:    stage_x <= s_data[15:0];
          `PD_Y:    stage_y <= s_data[15:0];
          `PD_Z:    if (bank_sel) stage_z <= s_data[15:0];
          `PD_NIR:  if (bank_sel) stage_n <= s_data[15:0];
          `PD_B440: if (!bank_sel) stage_z <= s_data[15:0];
          `PD_B490: if (!bank_sel) stage_n <= s_data[15:0];
          default: begin
          end
        endcase
      end
      if (finish) begin
        shadow_n <= stage_n;
        shadow_x <= stage_x;
        shadow_y <= stage_y;
        shadow_z <= stage_z;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Register reads
  // --------------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= `ZERO_BYTE;
      reg_ack   <= 1'b0;
    end else if (ce) begin
      reg_ack <= rd | wr;
      if (rd) begin
        case (reg_addr)
          `ADDR_IRQ_PIN_SETUP: reg_rdata <= irq_pin_setup;
          `ADDR_RES_N_HI:      reg_rdata <= result_n_pair[15:8];
          `ADDR_RES_N_LO:      reg_rdata <= result_n_pair[7:0];
          `ADDR_RES_X_HI:      reg_rdata <= result_x_pair[15:8];
          `ADDR_RES_X_LO:      reg_rdata <= result_x_pair[7:0];
          `ADDR_RES_Y_HI:      reg_rdata <= result_y_pair[15:8];
          `ADDR_RES_Y_LO:      reg_rdata <= result_y_pair[7:0];
          `ADDR_RES_Z_HI:      reg_rdata <= result_z_pair[15:8];
          `ADDR_RES_Z_LO:      reg_rdata <= result_z_pair[7:0];
          `ADDR_CONV_CONTROL:  reg_rdata <= conv_ctl;
          `ADDR_INTEG_TIME:    reg_rdata <= integ_time;
          `ADDR_WAIT_TIME:     reg_rdata <= wait_time;
          `ADDR_BANK_SELECT:   reg_rdata <= {bank_reg, 7'h00};
          `ADDR_GAIN_DRIVE:    reg_rdata <= gain_and_drive_reg;
          `ADDR_AUTO_ZERO:     reg_rdata <= {az_done_bit, 3'h0, az_enables};
          `ADDR_TEMP_CONTROL:  reg_rdata <= temp_measure_control;
          `ADDR_TEMP_LOW:      reg_rdata <= temperature_raw_value[7:0];
          `ADDR_TEMP_HIGH:     reg_rdata <= {6'h00, temperature_raw_value[9:8]};
          `ADDR_FLAG_CLEAR:    reg_rdata <= {5'h00, done_flag, 2'h0};
          `ADDR_FLAG_ENABLE:   reg_rdata <= {5'h00, flag_en, 2'h0};
          default:             reg_rdata <= `ZERO_BYTE;
        endcase
      end
    end
  end
endmodule

//--- color_sense_ctrl_props.sv
// Concurrent checks on the ports of the color sensor controller.
// Assumes binding to color_sense_ctrl and one clock domain.
`timescale 1ns/100ps
`include "color_sense_regs.vh"

// ----------------------------------------------------------------------------
// Checker
// ----------------------------------------------------------------------------
module color_sense_ctrl_props #(
  parameter MIN_CONV_CYCLES = 10
) (
  input wire       core_clk,
  input wire       srst,
  input wire       ce,
  input wire [6:0] dev_addr,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire       reg_ack,
  input wire       integ_active,
  input wire [1:0] gain_sel,
  input wire       az_start,
  input wire       az_done,
  input wire       temp_start,
  input wire       conv_irq
);
  int unsigned high_len;
  logic        az_seen;

  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence s_write(a);
    ce && reg_wr && dev_addr == `DEV_I2C_ADDR && reg_addr == a;
  endsequence

  // A counter avoids long repetitions in the minimum length check.
  always @(posedge core_clk) begin
    if (srst) begin
      high_len <= 0;
      az_seen  <= 1'b0;
    end else begin
      high_len <= integ_active ? high_len + 1 : 0;
      az_seen  <= az_seen | az_done;
    end
  end

  a_ack_on_match: assert property (
    ce && (reg_wr || reg_rd) && dev_addr == `DEV_I2C_ADDR |=> reg_ack)
    else $error("missing ack");
  a_ack_foreign: assert property (
    ce && (reg_wr || reg_rd) && dev_addr != `DEV_I2C_ADDR |=> !reg_ack)
    else $error("ack for foreign address");
  a_gain_copy: assert property (
    s_write(`ADDR_GAIN_DRIVE) |-> ##2 gain_sel == $past(reg_wdata[1:0], 2))
    else $error("gain select mismatch");
  a_temp_pulse: assert property (
    s_write(`ADDR_TEMP_CONTROL) ##0 reg_wdata == `TEMP_CMD_START |=> temp_start ##1 !temp_start)
    else $error("bad temperature start pulse");
  a_temp_cause: assert property (
    $rose(temp_start) |-> $past(reg_wr && reg_addr == `ADDR_TEMP_CONTROL))
    else $error("unrequested temperature start");
  a_flag_clear: assert property (
    s_write(`ADDR_FLAG_CLEAR) ##0 reg_wdata[`BIT_FLAG] |-> ##2 !conv_irq)
    else $error("interrupt stuck after clear");
  a_conv_min: assert property (
    $fell(integ_active) |-> high_len >= MIN_CONV_CYCLES)
    else $error("integration too short");
  a_az_first: assert property (
    $rose(integ_active) |-> az_seen)
    else $error("integration before auto-zero");
  a_az_release: assert property (
    $fell(srst) |-> ##[1:3] az_start)
    else $error("no auto-zero after reset");
endmodule

bind color_sense_ctrl color_sense_ctrl_props #(.MIN_CONV_CYCLES(MIN_CONV_CYCLES)) chk (
  .core_clk(core_clk), .srst(srst), .ce(ce), .dev_addr(dev_addr), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_ack(reg_ack),
  .integ_active(integ_active), .gain_sel(gain_sel), .az_start(az_start),
  .az_done(az_done), .temp_start(temp_start), .conv_irq(conv_irq));

//--- front_end_model.sv
// Behavioural analog front end: sample stream, auto-zero and temperature converter.
// Assumes the controller's front end ports and one shared clock.
`timescale 1ns/100ps

// ----------------------------------------------------------------------------
// Front end model
// ----------------------------------------------------------------------------
module front_end_model #(
  parameter       AZ_LAT   = 20,
  parameter       TEMP_LAT = 6,
  parameter [9:0] TEMP_VAL = 10'h2B6
) (
  // Controller side
  input  wire        core_clk,
  input  wire        srst,
  input  wire        integ_active,
  input  wire        adc_ready,
  input  wire        az_start,
  input  wire        temp_start,
  // Front end outputs
  output reg         adc_valid,
  output reg  [2:0]  adc_chan,
  output reg  [15:0] adc_data,
  output reg         az_done,
  output reg         temp_done,
  output reg  [9:0]  temp_value
);
  reg [3:0] idx = 4'h0;
  integer   azc = 0;
  integer   tpc = 0;
  reg       took, rst_s, act_s, act_q = 1'b0, az_s, tp_s;

  initial begin
    {adc_valid, adc_chan, adc_data, az_done, temp_done, temp_value} = 0;
  end

  always @(posedge core_clk) begin
    took = adc_valid && adc_ready;
    rst_s = srst;
    act_s = integ_active;
    az_s = az_start;
    tp_s = temp_start;
    #1;
    // Nine words a burst overfill the eight-word buffer while nothing drains it.
    if (rst_s || (act_s && !act_q))
      idx = 4'h0;
    else if (took)
      idx = idx + 4'h1;
    act_q = act_s;
    adc_valid = !rst_s && idx < 4'h9;
    adc_chan = (idx > 4'h5) ? idx[2:0] - 3'h6 : idx[2:0];
    adc_data = adc_valid ? {({1'b0, adc_chan} + 4'h1), 12'h5C3} : ~adc_data;
    if (az_s)
      azc = AZ_LAT;
    else if (azc != 0)
      azc = azc - 1;
    az_done = (azc == 1);
    if (tp_s)
      tpc = TEMP_LAT;
    else if (tpc != 0)
      tpc = tpc - 1;
    temp_done = (tpc == 1);
    temp_value = temp_done ? TEMP_VAL : ~temp_value;
  end
endmodule

//--- color_sensor_conversion_control_test.sv
// Self-checking bench of the color sensor controller with a front end model.
// Assumes the register map header; timing shortened to 4 and 10 cycles.
`timescale 1ns/100ps
`include "color_sense_regs.vh"
`define CHK(got, exp) begin checked = checked + 1; if ((got) !== (exp)) begin \
  fail_count = fail_count + 1; $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end

// ----------------------------------------------------------------------------
// Bench
// ----------------------------------------------------------------------------
module color_sensor_conversion_control_test;
  localparam [9:0] TEMP_VAL = 10'h2B6;
  reg         core_clk = 0, srst = 1, ce = 1, reg_wr = 0, reg_rd = 0;
  reg  [6:0]  dev_addr = `DEV_I2C_ADDR;
  reg  [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, rb;
  wire [7:0]  reg_rdata;
  wire [15:0] adc_data;
  wire [9:0]  temp_value;
  wire [2:0]  adc_chan;
  wire [1:0]  gain_sel;
  wire        reg_ack, adc_valid, adc_ready, integ_active, bank_sel, az_start, az_done;
  wire        temp_start, temp_done, conv_irq;
  integer     fail_count = 0, checked = 0;

  color_sense_ctrl #(.STEP_CYCLES(4), .MIN_CONV_CYCLES(10)) uut (.core_clk(core_clk),
    .srst(srst), .ce(ce), .dev_addr(dev_addr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .adc_valid(adc_valid), .adc_chan(adc_chan), .adc_data(adc_data), .adc_ready(adc_ready),
    .integ_active(integ_active), .gain_sel(gain_sel), .bank_sel(bank_sel),
    .az_start(az_start), .az_done(az_done), .temp_start(temp_start), .temp_done(temp_done),
    .temp_value(temp_value), .conv_irq(conv_irq));
  front_end_model #(.TEMP_VAL(TEMP_VAL)) fe (.core_clk(core_clk), .srst(srst),
    .integ_active(integ_active), .adc_ready(adc_ready), .az_start(az_start),
    .temp_start(temp_start), .adc_valid(adc_valid), .adc_chan(adc_chan), .adc_data(adc_data),
    .az_done(az_done), .temp_done(temp_done), .temp_value(temp_value));

  always #4 core_clk = ~core_clk;

  task print_verdict;
    begin
      $display("checks=%0d mismatches=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  task give_up;
    begin
      fail_count = fail_count + 1;
      print_verdict;
    end
  endtask

  task tick(input integer n);
    begin
      repeat (n) @(posedge core_clk);
      #1;
    end
  endtask

  // Strobe stands one edge; the answer is taken a cycle on, then one idle cycle.
  task access(input [6:0] dev, input wr, input [7:0] a, input [7:0] d);
    begin
      {dev_addr, reg_addr, reg_wdata, reg_wr, reg_rd} = {dev, a, d, wr, !wr};
      tick(1);
      {dev_addr, reg_wr, reg_rd} = {`DEV_I2C_ADDR, 2'b00};
      rb = reg_rdata;
      `CHK(reg_ack, dev == `DEV_I2C_ADDR)
      tick(1);
    end
  endtask

  task wr(input [7:0] a, input [7:0] d);
    access(`DEV_I2C_ADDR, 1'b1, a, d);
  endtask

  task rd_chk(input [7:0] a, input [7:0] exp);
    begin
      access(`DEV_I2C_ADDR, 1'b0, a, 8'h00);
      `CHK(rb, exp)
    end
  endtask

  task poll(input [7:0] a, input [7:0] mask, input [7:0] exp);
    integer i;
    begin
      rb = ~exp;
      for (i = 0; (rb & mask) !== exp; i = i + 1) begin
        if (i > 300) give_up;
        access(`DEV_I2C_ADDR, 1'b0, a, 8'h00);
      end
    end
  endtask

  task wait_done(input use_irq);
    integer i;
    begin
      if (use_irq) begin
        for (i = 0; conv_irq !== 1'b1; i = i + 1) begin
          if (i > 500) give_up;
          tick(1);
        end
      end else
        poll(`ADDR_FLAG_CLEAR, 8'h04, 8'h04);
    end
  endtask

  task s_startup;
    begin
      rd_chk(`ADDR_IRQ_PIN_SETUP, `RESET_BYTE);
      rd_chk(`ADDR_FLAG_CLEAR, 8'h00);
      rd_chk(8'h30, 8'h00);
      access(7'h48, 1'b1, `ADDR_IRQ_PIN_SETUP, `IRQ_PIN_ON);
      rd_chk(`ADDR_IRQ_PIN_SETUP, 8'h00);
      tick(12);
      `CHK(adc_ready, 1'b0)
      poll(`ADDR_AUTO_ZERO, 8'h80, 8'h80);
    end
  endtask

  task s_autozero;
    begin
      wr(`ADDR_AUTO_ZERO, 8'h0F);
      access(`DEV_I2C_ADDR, 1'b0, `ADDR_AUTO_ZERO, 8'h00);
      `CHK(rb[7], 1'b0)
      poll(`ADDR_AUTO_ZERO, 8'h80, 8'h80);
    end
  endtask

  task s_gain;
    integer g;
    begin
      for (g = 0; g < 4; g = g + 1) begin
        wr(`ADDR_GAIN_DRIVE, g[7:0]);
        `CHK(gain_sel, g[1:0])
      end
    end
  endtask

  task s_temp;
    begin
      wr(`ADDR_TEMP_CONTROL, `TEMP_CMD_START);
      poll(`ADDR_TEMP_CONTROL, 8'hFF, `TEMP_STAT_DONE);
      rd_chk(`ADDR_TEMP_LOW, TEMP_VAL[7:0]);
      rd_chk(`ADDR_TEMP_HIGH, {6'h00, TEMP_VAL[9:8]});
      wr(`ADDR_TEMP_CONTROL, 8'h00);
    end
  endtask

  task wait_act(input v, output integer n);
    begin
      n = 0;
      while (integ_active !== v) begin
        n = n + 1;
        if (n > 500) give_up;
        tick(1);
      end
    end
  endtask

  // Two completions: the latched bank then surely used the new settings.
  task s_conv(input bank, input [7:0] int_t, input use_irq, input integer exp_len);
    integer k, len;
    reg [2:0] id;
    begin
      wr(`ADDR_FLAG_ENABLE, 8'h04);
      wr(`ADDR_IRQ_PIN_SETUP, use_irq ? `IRQ_PIN_ON : 8'h00);
      wr(`ADDR_BANK_SELECT, {bank, 7'h00});
      wr(`ADDR_INTEG_TIME, int_t);
      wr(`ADDR_WAIT_TIME, 8'h08);
      wr(`ADDR_CONV_CONTROL, 8'h01);
      wr(`ADDR_FLAG_CLEAR, 8'h04);
      wr(`ADDR_CONV_CONTROL, 8'h03);
      wait_act(1'b0, len);
      wait_act(1'b1, len);
      wait_act(1'b0, len);
      `CHK(len, exp_len)
      wait_done(use_irq);
      wr(`ADDR_FLAG_CLEAR, 8'h04);
      wait_done(use_irq);
      if (use_irq)
        rd_chk(`ADDR_FLAG_CLEAR, 8'h04);
      else
        `CHK(conv_irq, 1'b0)
      `CHK(bank_sel, bank)
      wr(`ADDR_CONV_CONTROL, 8'h83);
      for (k = 0; k < 4; k = k + 1) begin
        id = (k == 1) ? `PD_X : (k == 2) ? `PD_Y : (k == 0) ? (bank ? `PD_NIR : `PD_B490)
             : (bank ? `PD_Z : `PD_B440);
        rd_chk(`ADDR_RES_N_HI + 2 * k, {({1'b0, id} + 4'h1), 4'h5});
        rd_chk(`ADDR_RES_N_LO + 2 * k, 8'hC3);
      end
      wr(`ADDR_FLAG_CLEAR, 8'h04);
      tick(2);
      `CHK(conv_irq, 1'b0)
      rd_chk(`ADDR_FLAG_CLEAR, 8'h00);
      wr(`ADDR_CONV_CONTROL, 8'h00);
    end
  endtask

  initial begin
    repeat (12) @(posedge core_clk);
    #1;
    srst = 0;
    s_startup;
    s_autozero;
    s_gain;
    s_temp;
    s_conv(1'b0, 8'h00, 1'b1, 10);
    s_conv(1'b1, 8'h03, 1'b0, 16);
    print_verdict;
  end
endmodule
